// file: pff_pkg.sv
// package: constants, types and register map of the flow-control block
// assumes a single 100 MHz core clock shared by all users
package pff_pkg;
    localparam int PFF_NCH = 8;
    localparam int PFF_BW = 16;
    localparam int PFF_WIN = 32;
    localparam int PFF_WOUT = 8;
    typedef logic [PFF_BW-1:0] pff_cnt_t;
    typedef struct packed {
        pff_cnt_t used;
        pff_cnt_t free;
        logic eop;
    } pff_chan_s;
    typedef enum logic [1:0] {
        PFF_IDLE = 2'b00,
        PFF_SEND = 2'b01,
        PFF_REMOTE = 2'b10
    } pff_tx_e;
    typedef enum logic [1:0] {
        PFF_LINK_TX = 2'b00,
        PFF_LINK_RX = 2'b01,
        PFF_PHY_TX = 2'b10,
        PFF_PHY_RX = 2'b11
    } pff_role_e;
    localparam logic [7:0] PFF_CTRL_OFS = 8'h00;
    localparam logic [7:0] PFF_THR_OFS = 8'h04;
    localparam logic [7:0] PFF_BST_OFS = 8'h08;
    localparam logic [7:0] PFF_RB_OFS = 8'h0c;
    localparam logic [7:0] PFF_STAT_OFS = 8'h10;
    localparam int PFF_C_L3 = 0;
    localparam int PFF_C_POLL = 1;
    localparam int PFF_C_MULTI = 2;
    localparam int PFF_C_PERR = 3;
    localparam int PFF_C_ERRPIN = 4;
    localparam int PFF_C_ROLE = 5;
    localparam logic [7:0] PFF_CTRL_RST = 8'h00;
    localparam pff_cnt_t PFF_THR_RST = 16'h0040;
    localparam pff_cnt_t PFF_BST_RST = 16'h0020;
    localparam pff_cnt_t PFF_RB_RST = 16'h0010;
endpackage

// file: pff_flow.sv
// flow control, arbitration and parity path of a packet link interface
// assumes fill levels and moved-byte pulses come from logic on i_clk;
// link pins and the link clock are asynchronous and are synchronised here
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pff_flow import pff_pkg::*; #(
    parameter int NCH = PFF_NCH,
    parameter int WIN = PFF_WIN,
    parameter int WOUT = PFF_WOUT,
    parameter bit ODD_PAR = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire pff_chan_s [NCH-1:0] i_chan,
    input wire logic i_moved,
    input wire logic [7:0] i_moved_bytes,
    output logic o_xfer_en,
    output logic [((NCH>1)?$clog2(NCH):1)-1:0] o_ch,
    input wire logic i_link_clk,
    input wire logic i_ptpa,
    input wire logic i_stpa,
    input wire logic i_prpa,
    input wire logic i_renb_n,
    input wire logic [NCH-1:0] i_dtpa,
    input wire logic [NCH-1:0] i_drpa,
    input wire logic [((NCH>1)?$clog2(NCH):1)-1:0] i_adr,
    output logic o_ptpa,
    output logic o_stpa,
    output logic o_prpa,
    output logic o_renb_n,
    output logic [NCH-1:0] o_dtpa,
    output logic [NCH-1:0] o_drpa,
    input wire logic i_be_avail,
    input wire logic i_be_moved,
    input wire logic [7:0] i_be_bytes,
    output logic o_be_go,
    input wire logic i_in_valid,
    input wire logic [WIN-1:0] i_in_data,
    input wire logic i_in_par,
    input wire logic i_in_eop,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WOUT-1:0] o_out_data,
    output logic o_out_par,
    output logic o_out_eop,
    output logic o_err,
    input wire logic i_out_ready
);
    localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam int RAT = WIN / WOUT;
    localparam int IW = (RAT > 1) ? $clog2(RAT) : 1;
    localparam int LW = 4 + 2 * NCH + CW;

    typedef struct packed {
        logic [7:0] ctrl;
        pff_cnt_t thr;
        pff_cnt_t bst;
        pff_cnt_t rb;
        logic [LW:0] s1;
        logic [LW:0] s2;
        logic clk_d;
        logic [LW-1:0] lk;
        pff_tx_e st;
        logic [CW-1:0] ch;
        pff_cnt_t bcnt;
        pff_cnt_t rcnt;
        pff_cnt_t be_rcnt;
        logic [NCH-1:0] space;
        logic [NCH-1:0] dav;
        logic [NCH-1:0] rxfull;
        logic renb_n;
        logic [31:0] rdata;
        logic [WIN-1:0] hd;
        logic hv;
        logic he;
        logic hp;
        logic [IW-1:0] idx;
        logic pkt;
    } pff_state_s;

    pff_state_s r_reg;
    pff_state_s r_next;

    function automatic logic pick(logic [NCH-1:0] v, logic [CW-1:0] i);
        return (int'(i) < NCH) ? v[i] : 1'b0;
    endfunction

    function automatic pff_cnt_t addb(pff_cnt_t a, logic [7:0] b);
        logic [PFF_BW:0] s;
        s = {1'b0, a} + {{(PFF_BW-7){1'b0}}, b};
        return s[PFF_BW] ? '1 : s[PFF_BW-1:0];
    endfunction

    function automatic logic [CW-1:0] nxt(logic [CW-1:0] c);
        return (int'(c) >= NCH - 1) ? '0 : CW'(c + 1'b1);
    endfunction

    function automatic logic par_out(logic [WOUT-1:0] d, logic e, logic m);
        return m ? e : ((^d) ^ ODD_PAR ^ e);
    endfunction

    logic l3;
    logic poll;
    logic multi;
    logic perr_mode;
    logic errpin;
    pff_role_e role;
    logic tick;
    logic lk_ptpa;
    logic lk_stpa;
    logic lk_prpa;
    logic lk_renb;
    logic [NCH-1:0] lk_dtpa;
    logic [NCH-1:0] lk_drpa;
    logic [CW-1:0] lk_adr;
    logic [NCH-1:0] ne;
    logic perm;
    logic en;
    logic all_ok;
    logic any_full;
    logic perr_in;
    logic last;
    pff_cnt_t bsum;
    logic [WIN-1:0] sh;

    assign l3 = r_reg.ctrl[PFF_C_L3];
    assign poll = r_reg.ctrl[PFF_C_POLL];
    assign multi = r_reg.ctrl[PFF_C_MULTI];
    assign perr_mode = r_reg.ctrl[PFF_C_PERR];
    assign errpin = r_reg.ctrl[PFF_C_ERRPIN];
    assign role = pff_role_e'(r_reg.ctrl[PFF_C_ROLE+:2]);
    assign lk_ptpa = r_reg.lk[0];
    assign lk_stpa = r_reg.lk[1];
    assign lk_prpa = r_reg.lk[2];
    assign lk_renb = r_reg.lk[3];
    assign lk_dtpa = r_reg.lk[4+:NCH];
    assign lk_drpa = r_reg.lk[4+NCH+:NCH];
    assign lk_adr = r_reg.lk[4+2*NCH+:CW];
    assign perr_in = (^i_in_data) ^ i_in_par ^ ODD_PAR;
    assign last = (int'(r_reg.idx) == RAT - 1);
    assign sh = r_reg.hd >> WOUT;

    always_comb begin
        r_next = r_reg;
        // link clock sampled like any other pin, edge found after sync
        r_next.s1 = {i_link_clk, i_adr, i_drpa, i_dtpa,
                     i_renb_n, i_prpa, i_stpa, i_ptpa};
        r_next.s2 = r_reg.s1;
        r_next.clk_d = r_reg.s2[LW];
        tick = r_reg.s2[LW] & ~r_reg.clk_d;
        if (tick) begin
            r_next.lk = r_reg.s2[LW-1:0];
        end

        r_next.rdata = 32'h0;
        if (i_wr) begin
            unique case (i_addr)
                PFF_CTRL_OFS: r_next.ctrl = i_wdata[7:0];
                PFF_THR_OFS: r_next.thr = i_wdata[PFF_BW-1:0];
                PFF_BST_OFS: r_next.bst = i_wdata[PFF_BW-1:0];
                PFF_RB_OFS: r_next.rb = i_wdata[PFF_BW-1:0];
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                PFF_CTRL_OFS: r_next.rdata = {24'h0, r_reg.ctrl};
                PFF_THR_OFS: r_next.rdata = {16'h0, r_reg.thr};
                PFF_BST_OFS: r_next.rdata = {16'h0, r_reg.bst};
                PFF_RB_OFS: r_next.rdata = {16'h0, r_reg.rb};
                PFF_STAT_OFS: r_next.rdata = 32'({r_reg.space,
                    r_reg.rxfull, 3'h0, r_reg.pkt, r_reg.renb_n,
                    r_reg.st, r_reg.ch});
                default: r_next.rdata = 32'h0;
            endcase
        end

        all_ok = 1'b1;
        any_full = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            ne[i] = (role == PFF_LINK_RX) ? 1'b1 :
                (i_chan[i].used > r_reg.thr) | i_chan[i].eop;
            all_ok &= (i_chan[i].free >= r_reg.thr);
            any_full |= (i_chan[i].free == '0);
            if (tick) begin
                if (i_chan[i].free >= r_reg.thr) begin
                    r_next.space[i] = 1'b1;
                    r_next.rxfull[i] = 1'b0;
                end else if (i_chan[i].free < r_reg.bst) begin
                    r_next.space[i] = 1'b0;
                    r_next.rxfull[i] = 1'b1;
                end
                if (i_chan[i].used > r_reg.thr) begin
                    r_next.dav[i] = 1'b1;
                end else if (i_chan[i].used <= r_reg.bst) begin
                    r_next.dav[i] = 1'b0;
                end
            end
        end
        if (tick) begin
            if (any_full) begin
                r_next.renb_n = 1'b1;
            end else if (all_ok) begin
                r_next.renb_n = 1'b0;
            end
        end

        unique case (role)
            PFF_LINK_TX: perm = poll ? (lk_ptpa & lk_stpa) :
                pick(lk_dtpa, r_reg.ch);
            PFF_LINK_RX: perm = ~l3 & ~pick(r_reg.rxfull, r_reg.ch) &
                (poll ? lk_prpa : pick(lk_drpa, r_reg.ch));
            PFF_PHY_RX: perm = ~lk_renb;
            PFF_PHY_TX: perm = 1'b0;
        endcase

        en = 1'b0;
        bsum = addb(r_reg.bcnt, i_moved_bytes);
        unique case (r_reg.st)
            PFF_IDLE: begin
                if (pick(ne, r_reg.ch) & perm) begin
                    r_next.st = PFF_SEND;
                    r_next.bcnt = '0;
                end else if (multi) begin
                    r_next.ch = nxt(r_reg.ch);
                end
            end
            PFF_SEND: begin
                en = (r_reg.bcnt < r_reg.bst) & pick(ne, r_reg.ch) &
                    perm;
                if (i_moved) begin
                    r_next.bcnt = bsum;
                end
                if ((i_moved & (bsum >= r_reg.bst)) |
                    ~pick(ne, r_reg.ch)) begin
                    r_next.st = PFF_IDLE;
                    r_next.ch = multi ? nxt(r_reg.ch) : r_reg.ch;
                end else if (~perm) begin
                    r_next.rcnt = '0;
                    r_next.st = (role == PFF_LINK_TX) ?
                        PFF_REMOTE : PFF_IDLE;
                end
            end
            PFF_REMOTE: begin
                en = (r_reg.rcnt < r_reg.rb) & (r_reg.bcnt < r_reg.bst) &
                    pick(ne, r_reg.ch);
                if (i_moved) begin
                    r_next.rcnt = addb(r_reg.rcnt, i_moved_bytes);
                    r_next.bcnt = bsum;
                end
                if (~en) begin
                    r_next.st = PFF_IDLE;
                    r_next.ch = multi ? nxt(r_reg.ch) : r_reg.ch;
                end
            end
            default: r_next.st = PFF_IDLE;
        endcase

        if (i_be_avail) begin
            r_next.be_rcnt = '0;
        end else if (i_be_moved & (r_reg.be_rcnt < r_reg.rb)) begin
            r_next.be_rcnt = addb(r_reg.be_rcnt, i_be_bytes);
        end

        if (i_in_valid & ~r_reg.hv) begin
            r_next.hd = i_in_data;
            r_next.hv = 1'b1;
            r_next.he = i_in_eop;
            r_next.hp = perr_in;
            r_next.idx = '0;
            r_next.pkt = r_reg.pkt | perr_in;
        end else if (r_reg.hv & i_out_ready) begin
            if (last) begin
                r_next.hv = 1'b0;
                if (r_reg.he) begin
                    r_next.pkt = 1'b0;
                end
            end else begin
                r_next.hd = sh;
                r_next.idx = IW'(r_reg.idx + 1'b1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r_reg <= '0;
            r_reg.ctrl <= PFF_CTRL_RST;
            r_reg.thr <= PFF_THR_RST;
            r_reg.bst <= PFF_BST_RST;
            r_reg.rb <= PFF_RB_RST;
            r_reg.renb_n <= 1'b1;
            r_reg.be_rcnt <= '1;
            r_reg.st <= PFF_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rdata = r_reg.rdata;
    assign o_xfer_en = en;
    assign o_ch = r_reg.ch;
    assign o_ptpa = (role == PFF_PHY_TX) & poll &
        pick(r_reg.space, lk_adr);
    assign o_stpa = o_ptpa & l3;
    assign o_dtpa = (role == PFF_PHY_TX && !poll) ? r_reg.space : '0;
    assign o_prpa = (role == PFF_PHY_RX) & ~l3 & poll &
        pick(r_reg.dav, lk_adr);
    assign o_drpa = (role == PFF_PHY_RX && !l3 && !poll) ? r_reg.dav : '0;
    assign o_renb_n = (role != PFF_LINK_RX) ? 1'b1 :
        (l3 ? r_reg.renb_n : ~en);
    assign o_be_go = i_be_avail | (r_reg.be_rcnt < r_reg.rb);
    assign o_in_ready = ~r_reg.hv;
    assign o_out_valid = r_reg.hv;
    assign o_out_data = r_reg.hd[WOUT-1:0];
    assign o_out_par = par_out(r_reg.hd[WOUT-1:0], r_reg.hp,
        perr_mode);
    assign o_out_eop = r_reg.hv & r_reg.he & last;
    assign o_err = errpin & o_out_eop & r_reg.pkt;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    par_pass_a: assert property (
        o_out_valid && !perr_mode && r_reg.hp |->
        o_out_par != ((^o_out_data) ^ ODD_PAR))
        else $error("pass-through parity not corrupted");
    par_repeat_a: assert property (
        o_out_valid && i_out_ready && !last && r_reg.hp && perr_mode
        && !i_wr |=> o_out_valid && o_out_par)
        else $error("error not repeated on derived word");
    eop_err_a: assert property (
        o_out_valid && r_reg.he && last && r_reg.hp && errpin |-> o_err)
        else $error("packet error missing at end of packet");
    renb_full_a: assert property (
        tick && any_full |=> r_reg.renb_n)
        else $error("receive enable not high when full");
    renb_room_a: assert property (
        tick && all_ok && !any_full |=> !r_reg.renb_n)
        else $error("receive enable not low with room");
    burst_cap_a: assert property (
        r_reg.st != PFF_IDLE && r_reg.bcnt >= r_reg.bst |-> !o_xfer_en)
        else $error("transfer beyond burst size");
    remote_cap_a: assert property (
        r_reg.st == PFF_REMOTE && r_reg.rcnt >= r_reg.rb |-> !o_xfer_en)
        else $error("transfer beyond remote burst");
    be_stop_a: assert property (
        !i_be_avail && r_reg.be_rcnt >= r_reg.rb |-> !o_be_go)
        else $error("back-end source did not stop");
    space_set_a: assert property (
        tick && i_chan[0].free >= r_reg.thr && !i_wr |=> r_reg.space[0])
        else $error("space not signalled at threshold");
    rr_step_a: assert property (
        r_reg.st == PFF_IDLE && multi && !(pick(ne, r_reg.ch) && perm)
        && int'(r_reg.ch) < NCH - 1 |=> int'(r_reg.ch) ==
        int'($past(r_reg.ch)) + 1)
        else $error("arbiter did not step by one");
endmodule

// file: pff_far_end.sv
// partner: far-end link device, makes the link clock and status pins
// assumes the bench sets the offered space and the receive enable
`timescale 1ns/1ps
module pff_far_end import pff_pkg::*; #(
    parameter int NCH = PFF_NCH,
    parameter int CW = 3
) (
    input wire logic [NCH-1:0] i_space,
    input wire logic i_renb_n,
    input wire logic [CW-1:0] i_poll,
    input wire logic [CW-1:0] i_ch,
    output logic o_link_clk,
    output logic o_ptpa,
    output logic o_stpa,
    output logic o_prpa,
    output logic o_renb_n,
    output logic [NCH-1:0] o_dtpa,
    output logic [NCH-1:0] o_drpa,
    output logic [CW-1:0] o_adr
);
    initial begin
        o_link_clk = 1'b0;
        forever #80 o_link_clk = ~o_link_clk;
    end
    initial begin
        {o_ptpa, o_stpa, o_prpa, o_dtpa, o_drpa, o_adr} = '0;
        o_renb_n = 1'b1;
    end
    // pins move on the falling edge, stable at the rising one
    always @(negedge o_link_clk) begin
        o_dtpa <= i_space;
        o_drpa <= i_space;
        o_ptpa <= i_space[i_ch];
        o_stpa <= i_space[i_ch];
        o_prpa <= i_space[i_ch];
        o_renb_n <= i_renb_n;
        o_adr <= i_poll;
    end
endmodule

// file: pff_flow_test.sv
// testbench: flow control, arbitration and parity path
// assumes the partner model stands at the link pins
`timescale 1ns/1ps
module pff_flow_test;
    import pff_pkg::*;
    localparam int N = PFF_NCH;
    logic clk, rst, wr, rd, move_on, in_valid, in_par, in_eop, in_ready;
    logic out_valid, out_par, out_eop, err, xfer_en, be_avail, be_go;
    logic lclk, ptpa, stpa, prpa, renb_n, renb_cmd, be_mv, pk;
    logic sp_out, rp_out, rn_out;
    wire logic moved, be_moved;
    logic [7:0] addr, mbytes, out_data;
    logic [31:0] wdata, rdata, in_data;
    logic [2:0] ch, adr, poll;
    logic [N-1:0] space, dtpa, drpa, dt_out, dr_out;
    pff_chan_s [N-1:0] chan;
    int errors, compares, cyc;
    assign moved = xfer_en & move_on;
    assign be_moved = be_mv & be_go;
    pff_flow pff_flow_i (.i_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_chan(chan), .i_moved(moved), .i_moved_bytes(mbytes),
        .o_xfer_en(xfer_en), .o_ch(ch), .i_link_clk(lclk), .i_ptpa(ptpa),
        .i_stpa(stpa), .i_prpa(prpa), .i_renb_n(renb_n), .i_dtpa(dtpa),
        .i_drpa(drpa), .i_adr(adr), .o_ptpa(sp_out), .o_stpa(),
        .o_prpa(rp_out), .o_renb_n(rn_out), .o_dtpa(dt_out),
        .o_drpa(dr_out), .i_be_avail(be_avail), .i_be_moved(be_moved),
        .i_be_bytes(mbytes), .o_be_go(be_go), .i_in_valid(in_valid),
        .i_in_data(in_data), .i_in_par(in_par), .i_in_eop(in_eop),
        .o_in_ready(in_ready), .o_out_valid(out_valid),
        .o_out_data(out_data), .o_out_par(out_par), .o_out_eop(out_eop),
        .o_err(err), .i_out_ready(1'b1));
    pff_far_end #(.NCH(N), .CW(3)) pff_far_end_i (.i_space(space),
        .i_renb_n(renb_cmd), .i_poll(poll), .i_ch(ch), .o_link_clk(lclk),
        .o_ptpa(ptpa), .o_stpa(stpa), .o_prpa(prpa), .o_renb_n(renb_n),
        .o_dtpa(dtpa), .o_drpa(drpa), .o_adr(adr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic cfg(input logic [7:0] c, input pff_cnt_t t, b);
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wreg(PFF_CTRL_OFS, {24'h0, c});
        wreg(PFF_THR_OFS, {16'h0, t});
        wreg(PFF_BST_OFS, {16'h0, b});
    endtask
    function automatic logic exp_par(logic [7:0] s, logic b, m);
        return m ? b : (^s ^ b);
    endfunction
    // one wide word in, four narrow slices out, low byte first
    task automatic wd(input logic [31:0] d, input logic b, e, m);
        int j;
        int n;
        logic r;
        logic [7:0] s;
        @(posedge clk);
        in_valid <= 1'b1;
        in_data <= d;
        in_par <= ^d ^ b;
        in_eop <= e;
        r = 1'b0;
        n = 0;
        while (!r && n < 50) begin
            @(negedge clk);
            r = in_ready;
            @(posedge clk);
            n++;
        end
        in_valid <= 1'b0;
        pk = pk | b;
        j = 0;
        while (j < 4 && n < 100) begin
            @(negedge clk);
            n++;
            if (out_valid) begin
                s = d[8*j +: 8];
                chk("slice", s, out_data);
                chk("par", exp_par(s, b, m), out_par);
                chk("eop", e && j == 3, out_eop);
                if (e && j == 3) chk("err", pk, err);
                j++;
            end
        end
        chk("slices", 4, j);
        if (e) pk = 1'b0;
    endtask
    initial begin
        logic [31:0] v;
        pff_cnt_t thr, bst;
        pff_cnt_t us[N];
        pff_cnt_t fr[N];
        logic [1:0] rl;
        logic l3, pl, hi, z, g;
        int by, n;
        int seq[3] = '{0, 1, 0};
        {rst, wr, rd, move_on, in_valid, in_par, in_eop, be_mv, pk} = 9'h100;
        {addr, wdata, in_data, poll, chan} = '0;
        mbytes = 8'h04;
        be_avail = 1'b1;
        renb_cmd = 1'b1;
        space = '1;
        void'($urandom(32'hcaf0));
        cfg(PFF_CTRL_RST, PFF_THR_RST, PFF_BST_RST);
        rreg(PFF_RB_OFS, v);
        chk("remote", {16'h0, PFF_RB_RST}, v);
        rreg(8'h14, v);
        chk("unmapped", 0, v);
        chk("be_go", 1, be_go);
        @(posedge clk);
        be_avail <= 1'b0;
        be_mv <= 1'b1;
        by = 0;
        repeat (8) begin
            @(negedge clk);
            if (be_go) by += 4;
        end
        chk("be_rb", PFF_RB_RST, by);
        @(posedge clk);
        be_avail <= 1'b1;
        be_mv <= 1'b0;
        @(negedge clk);
        chk("be_go", 1, be_go);
        for (int t = 0; t < 24; t++) begin
            rl = 2'(t % 3 + 1);
            l3 = ((t / 6) % 2) == 1;
            pl = ((t / 12) % 2) == 1;
            thr = 16'($urandom_range(40, 100));
            bst = 16'($urandom_range(8, 40));
            hi = 1'b1;
            z = 1'b0;
            @(posedge clk);
            poll <= 3'($urandom_range(0, 7));
            renb_cmd <= 1'b1;
            for (int i = 0; i < N; i++) begin
                fr[i] = (t % 2 == 1) ? 16'($urandom_range(thr, thr + 20))
                                     : 16'($urandom_range(0, thr + 20));
                if (t % 2 == 0 && i == t % N) fr[i] = '0;
                us[i] = 16'($urandom_range(0, thr + 20));
                if (rl == 2'd3 && i == 0) us[i] = thr + 16'h0001;
                hi &= fr[i] >= thr;
                z |= fr[i] == 16'h0000;
                chan[i] <= '{us[i], fr[i], 1'b0};
            end
            cfg({1'b0, rl, 3'b000, pl, l3}, thr, bst);
            repeat (60) @(posedge clk);
            @(negedge clk);
            case (rl)
                2'd1: if (l3) begin
                    if (z) chk("renb", 1, rn_out);
                    else if (hi) chk("renb", 0, rn_out);
                end else begin
                    rreg(PFF_STAT_OFS, v);
                    for (int i = 0; i < N; i++) begin
                        if (fr[i] >= thr) chk("rxfull", 0, v[10+i]);
                        else if (fr[i] < bst) chk("rxfull", 1, v[10+i]);
                    end
                end
                2'd2: for (int i = 0; i < N; i++) begin
                    g = pl ? sp_out : dt_out[i];
                    if (!pl || i == poll) begin
                        if (fr[i] >= thr) chk("space", 1, g);
                        else if (fr[i] < bst) chk("space", 0, g);
                    end
                end
                default: if (l3) begin
                    chk("hold", 0, xfer_en);
                    @(posedge clk);
                    renb_cmd <= 1'b0;
                    repeat (60) @(posedge clk);
                    @(negedge clk);
                    chk("drain", 1, xfer_en);
                end else begin
                    for (int i = 0; i < N; i++) begin
                        g = pl ? rp_out : dr_out[i];
                        if (!pl || i == poll) begin
                            if (us[i] > thr) chk("dav", 1, g);
                            else if (us[i] <= bst) chk("dav", 0, g);
                        end
                    end
                end
            endcase
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            move_on <= 1'b0;
            for (int i = 0; i < N; i++) begin
                chan[i] <= '{(i == 0) ? PFF_THR_RST + 16'h0001 :
                    {15'h0, i == 1}, 16'h0100, i == 1};
            end
            cfg({6'b000000, p[0], 1'b1}, PFF_THR_RST, PFF_BST_RST);
            // channel 0 holds its first burst while move_on is low
            repeat (60) @(posedge clk);
            wreg(PFF_CTRL_OFS, {29'h0, 1'b1, p[0], 1'b1});
            @(posedge clk);
            move_on <= 1'b1;
            n = 0;
            for (int k = 0; k < 3; k++) begin
                @(negedge clk);
                while (!xfer_en && n < 300) begin
                    @(negedge clk);
                    n++;
                end
                chk("channel", seq[k], ch);
                by = 0;
                while (xfer_en && n < 300) begin
                    by += 4;
                    @(negedge clk);
                    n++;
                end
                chk("burst", PFF_BST_RST, by);
            end
        end
        @(posedge clk);
        move_on <= 1'b0;
        cfg(8'h03, PFF_THR_RST, PFF_BST_RST);
        repeat (60) @(posedge clk);
        space <= '0;
        repeat (60) @(posedge clk);
        move_on <= 1'b1;
        by = 0;
        repeat (20) begin
            @(negedge clk);
            if (xfer_en) by += 4;
        end
        chk("rburst", PFF_RB_RST, by);
        space <= '1;
        for (int m = 0; m < 2; m++) begin
            cfg({3'b000, 1'b1, m[0], 3'b000}, PFF_THR_RST, PFF_BST_RST);
            wd($urandom(), 1'b1, 1'b0, m[0]);
            wd($urandom(), 1'b0, 1'b1, m[0]);
            wd($urandom(), 1'b1, 1'b1, m[0]);
            wd($urandom(), 1'b0, 1'b1, m[0]);
        end
        complete_run();
    end
endmodule
